// ---- rtl/smig_defines.svh ----
// address map, reset values, field positions and timing counts of the sync monitor bank
`ifndef SMIG_DEFINES_SVH
`define SMIG_DEFINES_SVH

// register addresses on the processor port
`define SMIG_ADDR_SYNC_PHASE 8'h7B
`define SMIG_ADDR_SYNC_MON 8'h7C
`define SMIG_ADDR_IRQ_CFG 8'h7D
`define SMIG_ADDR_GUARD 8'h7E
`define SMIG_ADDR_HOST_SEL 8'h7F

// reset values
`define SMIG_RST_SYNC_PHASE 8'h00
`define SMIG_RST_SYNC_MON 8'h2B
`define SMIG_RST_IRQ_CFG 8'h02
`define SMIG_RST_GUARD 8'h85
`define SMIG_RST_HOST_SEL 8'h00
`define SMIG_READ_NONE 8'h00

// write guard keys
`define SMIG_KEY_OPEN 8'h85
`define SMIG_KEY_ONCE 8'h86
`define SMIG_KEY_LOCKED 8'h00

// field positions
`define SMIG_RECAL_BIT 7
`define SMIG_LIMIT_MSB 6
`define SMIG_LIMIT_LSB 4
`define SMIG_ASSOC_MSB 3
`define SMIG_ASSOC_LSB 0
`define SMIG_SKEW_MSB 1
`define SMIG_SKEW_LSB 0
`define SMIG_REUSE_BIT 2
`define SMIG_FLOAT_BIT 1
`define SMIG_POL_BIT 0
`define SMIG_HOST_MSB 2
`define SMIG_ASSOC_NONE 4'h0

// timing: unit interval and clock period in ns, half unit interval in cycles
`define SMIG_CLK_NS 10
`define SMIG_UI_NS 80
`define SMIG_HUI_CYC ((`SMIG_UI_NS / 2) / `SMIG_CLK_NS)
`define SMIG_FRAME_HUI 8'h40
`define SMIG_HALF_FRAME 8'h20
`define SMIG_RAMP_DIV 8'h10
`define SMIG_STRAP_WAIT 2'h3

`endif

// ---- rtl/smig_pkg.sv ----
// types shared by the sync monitor register bank
package smig_pkg;

    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } smig_host_req_t;

    typedef struct packed {
        logic locked;
        logic [3:0] src;
    } smig_lock_t;

    typedef enum logic [2:0] {
        SMIG_TRACK = 3'h0,
        SMIG_GO_ZERO = 3'h1,
        SMIG_DIV_RST = 3'h2,
        SMIG_GO_BACK = 3'h3,
        SMIG_FINISH = 3'h4
    } smig_ramp_st_t;

    typedef enum logic [1:0] {
        SMIG_SKEW_TARGET = 2'h0,
        SMIG_SKEW_EARLY_HALF = 2'h1,
        SMIG_SKEW_LATE_ONE = 2'h2,
        SMIG_SKEW_LATE_HALF = 2'h3
    } smig_skew_t;

endpackage

// ---- rtl/smig_phase_ramp.sv ----
// output phase offset ramp and recalibration sequencer
`timescale 1ns/1ps
`include "smig_defines.svh"

module smig_phase_ramp
    import smig_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic step_en,
    input wire logic start,
    input wire logic [15:0] target,
    output logic [15:0] offset,
    output logic holdover,
    output logic div_reset,
    output logic done
);

    typedef struct packed {
        smig_ramp_st_t st;
        logic [15:0] offset;
        logic holdover;
        logic div_reset;
        logic done;
    } smig_ramp_s_t;

    smig_ramp_s_t s_ff;
    smig_ramp_s_t nxt_s;
    logic [15:0] goal;

    // next state: step toward the goal, then walk the recalibration sequence
    always_comb
    begin
        nxt_s = s_ff;
        nxt_s.div_reset = 1'b0;
        nxt_s.done = 1'b0;
        goal = (s_ff.st == SMIG_GO_ZERO) ? 16'h0000 : target;
        // (RULE_03) gradual offset ramp
        if (step_en && (s_ff.offset != goal))
        begin
            if ($signed(s_ff.offset) < $signed(goal))
                nxt_s.offset = s_ff.offset + 16'h0001;
            else
                nxt_s.offset = s_ff.offset - 16'h0001;
        end
        // (RULE_04) holdover recalibration sequence
        case (s_ff.st)
            SMIG_TRACK:
            begin
                if (start)
                begin
                    nxt_s.holdover = 1'b1;
                    nxt_s.st = SMIG_GO_ZERO;
                end
            end
            SMIG_GO_ZERO:
            begin
                if (s_ff.offset == 16'h0000)
                begin
                    nxt_s.div_reset = 1'b1;
                    nxt_s.st = SMIG_DIV_RST;
                end
            end
            SMIG_DIV_RST: nxt_s.st = SMIG_GO_BACK;
            SMIG_GO_BACK:
            begin
                if (s_ff.offset == target)
                    nxt_s.st = SMIG_FINISH;
            end
            SMIG_FINISH:
            begin
                nxt_s.holdover = 1'b0;
                nxt_s.done = 1'b1; // (RULE_05) end of sequence
                nxt_s.st = SMIG_TRACK;
            end
            default: nxt_s.st = SMIG_TRACK;
        endcase
    end

    // state register
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            s_ff <= '{SMIG_TRACK, 16'h0000, 1'b0, 1'b0, 1'b0};
        else
            s_ff <= nxt_s;
    end

    assign offset = s_ff.offset;
    assign holdover = s_ff.holdover;
    assign div_reset = s_ff.div_reset;
    assign done = s_ff.done;

    AST_RAMP_ONE_STEP: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE_03
        (s_ff.st == SMIG_TRACK && step_en && s_ff.offset != target && !start)
        |=> (offset - $past(offset) == 16'h0001) || ($past(offset) - offset == 16'h0001))
        else $error("offset did not move by one step");

    AST_DIV_RESET_AT_ZERO: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE_04
        div_reset |-> (offset == 16'h0000) && holdover)
        else $error("dividers reset away from zero offset or outside holdover");

    AST_DONE_LEAVES_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE_04
        done |-> !holdover && (offset == $past(target)))
        else $error("recalibration ended off target or still in holdover");

endmodule // smig_phase_ramp

// ---- rtl/smig_sync_mon.sv ----
// external sync alignment monitor
`timescale 1ns/1ps
`include "smig_defines.svh"

module smig_sync_mon
    import smig_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic hui_tick,
    input wire logic sync_pin,
    input wire logic [1:0] skew,
    input wire logic [2:0] limit,
    input wire logic enable,
    output logic aligned,
    output logic alarm
);

    typedef struct packed {
        logic meta;
        logic sync;
        logic sync_d;
        logic [7:0] hcnt;
        logic aligned;
        logic alarm;
    } smig_mon_s_t;

    smig_mon_s_t s_ff;
    smig_mon_s_t nxt_s;
    logic signed [8:0] err;
    logic signed [8:0] skew_hui;
    logic signed [8:0] adj;
    logic [8:0] mag;
    logic [8:0] lim_hui;

    // error, skew and limit in half unit intervals
    always_comb
    begin
        nxt_s = s_ff;
        nxt_s.meta = sync_pin;
        nxt_s.sync = s_ff.meta;
        nxt_s.sync_d = s_ff.sync;
        err = (s_ff.hcnt < `SMIG_HALF_FRAME) ? $signed({1'b0, s_ff.hcnt})
            : $signed({1'b0, s_ff.hcnt}) - $signed({1'b0, `SMIG_FRAME_HUI});
        // (RULE_01) sampling skew
        case (smig_skew_t'(skew))
            SMIG_SKEW_TARGET: skew_hui = 9'sh000;
            SMIG_SKEW_EARLY_HALF: skew_hui = -9'sh001;
            SMIG_SKEW_LATE_ONE: skew_hui = 9'sh002;
            SMIG_SKEW_LATE_HALF: skew_hui = 9'sh001;
            default: skew_hui = 9'sh000;
        endcase
        adj = err - skew_hui;
        mag = adj[8] ? 9'(-adj) : 9'(adj);
        // (RULE_07) limit in whole unit intervals, 2 to 7
        if (limit < 3'h1)
            lim_hui = 9'h004;
        else if (limit > 3'h6)
            lim_hui = 9'h00E;
        else
            lim_hui = {5'h00, limit + 3'h1, 1'b0};
        if (hui_tick)
            nxt_s.hcnt = (s_ff.hcnt == `SMIG_FRAME_HUI - 8'h01) ? 8'h00 : s_ff.hcnt + 8'h01;
        // (RULE_08) monitor only while tied to the locked input
        if (!enable)
        begin
            nxt_s.aligned = 1'b0;
            nxt_s.alarm = 1'b0;
        end
        else if (s_ff.sync_d && !s_ff.sync)
        begin
            // (RULE_02) falling edge within half a unit interval
            nxt_s.aligned = (mag <= 9'h001);
            // (RULE_06) alarm beyond the programmed limit
            nxt_s.alarm = (mag > lim_hui);
        end
    end

    // state register
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            s_ff <= '{1'b0, 1'b0, 1'b0, 8'h00, 1'b0, 1'b0};
        else
            s_ff <= nxt_s;
    end

    assign aligned = s_ff.aligned;
    assign alarm = s_ff.alarm;

    AST_ALARM_NEEDS_ENABLE: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE_08
        !enable |=> !alarm && !aligned)
        else $error("monitor flagged while not associated");

    AST_ALARM_NOT_ALIGNED: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE_06
        alarm |-> !aligned)
        else $error("alarm and aligned at once");

    AST_FLAG_ON_EDGE: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE_02
        (enable && s_ff.sync_d && !s_ff.sync && mag == 9'h000) |=> aligned)
        else $error("exact edge not reported aligned");

endmodule // smig_sync_mon

// ---- rtl/smig_regs.sv ----
// sync monitor, interrupt pin, write guard and host port select register bank
//
// What this block does
// (RULE_01) Two-bit skew moves sync sampling: on target, half early, one late, half late.
// (RULE_02) Zero skew: sync falling edge aligned if within half a unit interval.
// (RULE_03) With recalibrate clear, offset changes ramp gradually from old to new value.
// (RULE_04) Recalibrate: holdover, ramp to zero, reset dividers, ramp back, leave holdover.
// (RULE_05) Hardware clears the recalibrate bit when the sequence finishes.
// (RULE_06) Sync alarm rises when sync misaligns beyond the limit in unit intervals.
// (RULE_07) Three-bit limit picks the alarm threshold, two to seven unit intervals.
// (RULE_08) Association field ties sync to one input; zero unused; active only when locked there.
// (RULE_09) Pin reuse clear gives interrupts; set makes a general output following polarity.
// (RULE_10) Float clear drives the pin always; set drives it only while active.
// (RULE_11) Polarity bit zero signals interrupt low, one signals high.
// (RULE_12) Guard key: open allows writes, once allows one write, others block writes.
// (RULE_13) The guard key register stays writable in every protection state.
`timescale 1ns/1ps
`include "smig_defines.svh"

module smig_regs
    import smig_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire smig_host_req_t host_req,
    output logic [7:0] host_rdata,
    input wire logic irq_req,
    input wire smig_lock_t lock_info,
    input wire logic sync_pin,
    input wire logic [2:0] ups_strap,
    input wire logic [15:0] phase_target,
    output logic irq_pin_o,
    output logic irq_pin_oe,
    output logic sync_aligned,
    output logic sync_alarm,
    output logic [15:0] phase_offset,
    output logic holdover,
    output logic divider_reset,
    output logic [2:0] host_mode
);

    // ------------------------------------------------------------
    // state of the bank
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] sync_phase;
        logic [7:0] sync_mon;
        logic [7:0] irq_cfg;
        logic [7:0] guard;
        logic [7:0] host_sel;
        logic [7:0] rdata;
        logic irq_o;
        logic irq_oe;
        logic [2:0] strap_meta;
        logic [2:0] strap_sync;
        logic [1:0] strap_cnt;
        logic strap_done;
        logic [7:0] hui_cnt;
        logic hui_tick;
        logic [7:0] ramp_cnt;
        logic ramp_tick;
        logic recal_go;
    } smig_bank_s_t;

    smig_bank_s_t s_ff;
    smig_bank_s_t nxt_s;
    logic open_wr;
    logic data_wr;
    logic mon_enable;
    logic ramp_done;
    logic irq_active;

    // ------------------------------------------------------------
    // submodules
    // ------------------------------------------------------------

    // sync alignment monitor
    smig_sync_mon u_mon (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .hui_tick(s_ff.hui_tick),
        .sync_pin(sync_pin),
        .skew(s_ff.sync_phase[`SMIG_SKEW_MSB:`SMIG_SKEW_LSB]),
        .limit(s_ff.sync_mon[`SMIG_LIMIT_MSB:`SMIG_LIMIT_LSB]),
        .enable(mon_enable),
        .aligned(sync_aligned),
        .alarm(sync_alarm)
    );

    // phase offset ramp and recalibration
    smig_phase_ramp u_ramp (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .step_en(s_ff.ramp_tick),
        .start(s_ff.recal_go),
        .target(phase_target),
        .offset(phase_offset),
        .holdover(holdover),
        .div_reset(divider_reset),
        .done(ramp_done)
    );

    // (RULE_08) association decode
    assign mon_enable = lock_info.locked
        && (s_ff.sync_mon[`SMIG_ASSOC_MSB:`SMIG_ASSOC_LSB] != `SMIG_ASSOC_NONE)
        && (s_ff.sync_mon[`SMIG_ASSOC_MSB:`SMIG_ASSOC_LSB] == lock_info.src);

    // (RULE_12) write guard decode
    assign open_wr = (s_ff.guard == `SMIG_KEY_OPEN) || (s_ff.guard == `SMIG_KEY_ONCE);
    assign data_wr = host_req.wr && open_wr && (host_req.addr != `SMIG_ADDR_GUARD);

    // interrupt condition seen at the pin
    assign irq_active = irq_req && !s_ff.irq_cfg[`SMIG_REUSE_BIT];

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        nxt_s = s_ff;
        nxt_s.recal_go = 1'b0;

        // rate dividers: half unit interval and ramp step
        nxt_s.hui_tick = 1'b0;
        nxt_s.ramp_tick = 1'b0;
        if (s_ff.hui_cnt == 8'(`SMIG_HUI_CYC - 1))
        begin
            nxt_s.hui_cnt = 8'h00;
            nxt_s.hui_tick = 1'b1;
        end
        else
            nxt_s.hui_cnt = s_ff.hui_cnt + 8'h01;
        if (s_ff.ramp_cnt == `SMIG_RAMP_DIV - 8'h01)
        begin
            nxt_s.ramp_cnt = 8'h00;
            nxt_s.ramp_tick = 1'b1;
        end
        else
            nxt_s.ramp_cnt = s_ff.ramp_cnt + 8'h01;

        // (RULE_05) self clear of recalibrate when sequence ends
        if (ramp_done)
            nxt_s.sync_mon[`SMIG_RECAL_BIT] = 1'b0;

        // register writes
        if (data_wr)
        begin
            case (host_req.addr)
                `SMIG_ADDR_SYNC_PHASE: nxt_s.sync_phase = host_req.wdata;
                `SMIG_ADDR_SYNC_MON:
                begin
                    nxt_s.sync_mon = host_req.wdata;
                    // (RULE_04) start recalibration on a written one
                    // a one written as the last run ends starts a new run: set wins
                    if (host_req.wdata[`SMIG_RECAL_BIT]
                        && (!s_ff.sync_mon[`SMIG_RECAL_BIT] || ramp_done))
                        nxt_s.recal_go = 1'b1;
                    else if (s_ff.sync_mon[`SMIG_RECAL_BIT] && !ramp_done)
                        nxt_s.sync_mon[`SMIG_RECAL_BIT] = 1'b1;
                end
                `SMIG_ADDR_IRQ_CFG: nxt_s.irq_cfg = host_req.wdata;
                `SMIG_ADDR_HOST_SEL: nxt_s.host_sel = host_req.wdata;
                default: nxt_s.sync_phase = s_ff.sync_phase;
            endcase
            // (RULE_12) single write spends the key
            if (s_ff.guard == `SMIG_KEY_ONCE)
                nxt_s.guard = `SMIG_KEY_LOCKED;
        end

        // (RULE_13) key always writable
        if (host_req.wr && (host_req.addr == `SMIG_ADDR_GUARD))
            nxt_s.guard = host_req.wdata;

        // strap capture a few cycles after reset release
        nxt_s.strap_meta = ups_strap;
        nxt_s.strap_sync = s_ff.strap_meta;
        if (!s_ff.strap_done)
        begin
            if (s_ff.strap_cnt == `SMIG_STRAP_WAIT)
            begin
                nxt_s.host_sel = {5'h00, s_ff.strap_sync};
                nxt_s.strap_done = 1'b1;
            end
            else
                nxt_s.strap_cnt = s_ff.strap_cnt + 2'h1;
        end

        // read data
        if (host_req.rd)
        begin
            case (host_req.addr)
                `SMIG_ADDR_SYNC_PHASE: nxt_s.rdata = s_ff.sync_phase;
                `SMIG_ADDR_SYNC_MON: nxt_s.rdata = s_ff.sync_mon;
                `SMIG_ADDR_IRQ_CFG: nxt_s.rdata = s_ff.irq_cfg;
                `SMIG_ADDR_GUARD: nxt_s.rdata = s_ff.guard;
                `SMIG_ADDR_HOST_SEL: nxt_s.rdata = s_ff.host_sel;
                default: nxt_s.rdata = `SMIG_READ_NONE;
            endcase
        end

        // (RULE_09) general output follows polarity
        if (s_ff.irq_cfg[`SMIG_REUSE_BIT])
        begin
            nxt_s.irq_o = s_ff.irq_cfg[`SMIG_POL_BIT];
            nxt_s.irq_oe = 1'b1;
        end
        else
        begin
            // (RULE_11) active level from polarity
            nxt_s.irq_o = irq_active ? s_ff.irq_cfg[`SMIG_POL_BIT]
                : !s_ff.irq_cfg[`SMIG_POL_BIT];
            // (RULE_10) float when inactive
            nxt_s.irq_oe = !s_ff.irq_cfg[`SMIG_FLOAT_BIT] || irq_active;
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s_ff <= '0;
            s_ff.sync_phase <= `SMIG_RST_SYNC_PHASE;
            s_ff.sync_mon <= `SMIG_RST_SYNC_MON;
            s_ff.irq_cfg <= `SMIG_RST_IRQ_CFG;
            s_ff.guard <= `SMIG_RST_GUARD;
            s_ff.host_sel <= `SMIG_RST_HOST_SEL;
            s_ff.irq_o <= 1'b1;
        end
        else
            s_ff <= nxt_s;
    end

    assign host_rdata = s_ff.rdata;
    assign irq_pin_o = s_ff.irq_o;
    assign irq_pin_oe = s_ff.irq_oe;
    assign host_mode = s_ff.host_sel[`SMIG_HOST_MSB:0];

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_LOCKED_BLOCKS: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE_12
        (host_req.wr && host_req.addr == `SMIG_ADDR_IRQ_CFG && !open_wr)
        |=> $stable(s_ff.irq_cfg))
        else $error("write passed a locked guard");

    AST_ONCE_REVERTS: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE_12
        (s_ff.guard == `SMIG_KEY_ONCE && data_wr)
        |=> (s_ff.guard == `SMIG_KEY_LOCKED) ##1 (s_ff.guard == `SMIG_KEY_LOCKED || $past(host_req.wr)))
        else $error("single write key not spent");

    AST_KEY_WRITABLE: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE_13
        (host_req.wr && host_req.addr == `SMIG_ADDR_GUARD) |=> s_ff.guard == $past(host_req.wdata))
        else $error("guard key write lost");

    AST_IRQ_LEVEL: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE_11
        (irq_active && $stable(s_ff.irq_cfg))
        |=> irq_pin_o == $past(s_ff.irq_cfg[`SMIG_POL_BIT]))
        else $error("interrupt level does not follow polarity");

    AST_IRQ_FLOAT: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE_10
        (!irq_active && s_ff.irq_cfg[`SMIG_FLOAT_BIT] && !s_ff.irq_cfg[`SMIG_REUSE_BIT]
        && $stable(s_ff.irq_cfg)) |=> !irq_pin_oe)
        else $error("pin driven while floating and idle");

    AST_GPO_LEVEL: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE_09
        (s_ff.irq_cfg[`SMIG_REUSE_BIT] && $stable(s_ff.irq_cfg))
        |=> irq_pin_oe && irq_pin_o == $past(s_ff.irq_cfg[`SMIG_POL_BIT]))
        else $error("general output level wrong");

    AST_RECAL_CLEARS: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE_05
        ramp_done |=> !s_ff.sync_mon[`SMIG_RECAL_BIT] || s_ff.recal_go)
        else $error("recalibrate bit not cleared at end");

    AST_RECAL_HOLDS: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE_04
        s_ff.recal_go |=> holdover)
        else $error("recalibration did not enter holdover");

    // ------------------------------------------------------------
    // checks on open keys, recalibration start, association and pin drive
    // ------------------------------------------------------------
    AST_OPEN_ALLOWS: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE_12
        (host_req.wr && host_req.addr == `SMIG_ADDR_IRQ_CFG && s_ff.guard == `SMIG_KEY_OPEN)
        |=> s_ff.irq_cfg == $past(host_req.wdata))
        else $error("write lost under the open key");

    AST_ONCE_ALLOWS: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE_12
        (host_req.wr && host_req.addr == `SMIG_ADDR_IRQ_CFG && s_ff.guard == `SMIG_KEY_ONCE)
        |=> s_ff.irq_cfg == $past(host_req.wdata))
        else $error("write lost under the single write key");

    AST_RECAL_STARTS: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE_04
        (data_wr && host_req.addr == `SMIG_ADDR_SYNC_MON && host_req.wdata[`SMIG_RECAL_BIT]
        && !s_ff.sync_mon[`SMIG_RECAL_BIT]) |=> s_ff.recal_go)
        else $error("written recalibrate bit did not start a run");

    AST_UNTIED_QUIET: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE_08
        !mon_enable |=> !sync_alarm && !sync_aligned)
        else $error("sync flags raised while not tied to the locked input");

    AST_IRQ_DRIVEN: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE_10
        (!s_ff.irq_cfg[`SMIG_FLOAT_BIT] && !s_ff.irq_cfg[`SMIG_REUSE_BIT]) |=> irq_pin_oe)
        else $error("pin not driven with float clear");

endmodule // smig_regs

// ---- tb/smig_host_model.sv ----
// host processor model driving the register port
`timescale 1ns/1ps

module smig_host_model
    import smig_pkg::*;
(
    input wire logic ref_clk,
    output smig_host_req_t host_req
);
    // one access per call, launched and dropped on falling edges
    task automatic access(input logic w, input logic r, input logic [7:0] a,
                          input logic [7:0] d);
        @(negedge ref_clk);
        host_req = '{addr: a, wr: w, rd: r, wdata: d};
        @(negedge ref_clk);
        host_req = '0;
    endtask

    initial host_req = '0;
endmodule // smig_host_model

// ---- tb/tb_top.sv ----
// self-checking bench for the sync monitor register bank
`timescale 1ns/1ps
`include "smig_defines.svh"

module tb_top;
    import smig_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    smig_host_req_t host_req;
    logic [7:0] host_rdata;
    logic irq_req = 1'b0;
    smig_lock_t lock_info = '{locked: 1'b1, src: 4'hB};
    logic sync_pin = 1'b1;
    logic [2:0] ups_strap = 3'h0;
    logic [15:0] phase_target = 16'h0003;
    logic irq_pin_o, irq_pin_oe, sync_aligned, sync_alarm, holdover, divider_reset;
    logic [15:0] phase_offset;
    logic [2:0] host_mode;
    logic [7:0] exp_q[$];
    logic rd_seen = 1'b0;
    logic alarm_seen;
    logic [31:0] rv;
    int n_mismatch = 0;
    int check_count = 0;
    integer seed = 32'h727C48E9;
    int i;

    always #5 ref_clk = ~ref_clk;

    smig_regs smig_regs_inst(
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .host_req(host_req),
        .host_rdata(host_rdata),
        .irq_req(irq_req),
        .lock_info(lock_info),
        .sync_pin(sync_pin),
        .ups_strap(ups_strap),
        .phase_target(phase_target),
        .irq_pin_o(irq_pin_o),
        .irq_pin_oe(irq_pin_oe),
        .sync_aligned(sync_aligned),
        .sync_alarm(sync_alarm),
        .phase_offset(phase_offset),
        .holdover(holdover),
        .divider_reset(divider_reset),
        .host_mode(host_mode)
    );

    smig_host_model smig_host_model_inst(
        .ref_clk(ref_clk),
        .host_req(host_req)
    );

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        smig_host_model_inst.access(1'b1, 1'b0, a, d);
    endtask

    // note the expected byte, then issue the read
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        smig_host_model_inst.access(1'b0, 1'b1, a, 8'h00);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    // bounded wait for a level, then compare it
    task automatic wait_for(input string name, ref logic sig, input logic lvl, input int lim);
        int n = 0;
        while (sig !== lvl && n < lim)
        begin
            @(negedge ref_clk);
            n++;
        end
        chk(name, {15'h0000, lvl}, {15'h0000, sig});
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // read monitor: each returned byte against the oldest note
    always @(posedge ref_clk) rd_seen <= host_req.rd;
    always @(negedge ref_clk)
    begin
        if (rd_seen && exp_q.size() > 0)
            chk("host_rdata", {8'h00, exp_q.pop_front()}, {8'h00, host_rdata});
    end

    // watchdog far beyond the expected run length
    initial
    begin
        #200000;
        n_mismatch++;
        give_verdict();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        rv = $random(seed);
        ups_strap = rv[2:0];
        cyc(8);
        rst_b = 1'b1;
        cyc(8);
        rd(`SMIG_ADDR_SYNC_PHASE, `SMIG_RST_SYNC_PHASE);
        rd(`SMIG_ADDR_SYNC_MON, `SMIG_RST_SYNC_MON);
        rd(`SMIG_ADDR_IRQ_CFG, `SMIG_RST_IRQ_CFG);
        rd(`SMIG_ADDR_GUARD, `SMIG_RST_GUARD);
        rd(`SMIG_ADDR_HOST_SEL, {5'h00, ups_strap});
        rd(8'h7A, `SMIG_READ_NONE);
        chk("host_mode", {13'h0000, ups_strap}, {13'h0000, host_mode});
        $display("test reset values done");

        // offset tracks its target in small steps
        cyc(40);
        chk("phase_offset", 16'h0003, phase_offset);
        phase_target = 16'h0005;
        cyc(4);
        chk("offset jump", 16'h0000, {15'h0000, phase_offset === 16'h0005});
        cyc(40);
        chk("phase_offset", 16'h0005, phase_offset);
        wr(`SMIG_ADDR_SYNC_MON, `SMIG_RST_SYNC_MON | 8'h80);
        wait_for("holdover", holdover, 1'b1, 4);
        wait_for("divider_reset", divider_reset, 1'b1, 200);
        chk("offset at zero", 16'h0000, phase_offset);
        wait_for("holdover", holdover, 1'b0, 200);
        chk("phase_offset", 16'h0005, phase_offset);
        cyc(2);
        rd(`SMIG_ADDR_SYNC_MON, `SMIG_RST_SYNC_MON);
        $display("test phase ramp done");

        // random skew codes read back
        for (i = 0; i < 4; i++)
        begin
            rv = $random(seed);
            wr(`SMIG_ADDR_SYNC_PHASE, {6'h00, rv[1:0]});
            rd(`SMIG_ADDR_SYNC_PHASE, {6'h00, rv[1:0]});
        end

        // every pin config with the request low and high
        for (i = 0; i < 16; i++)
        begin
            irq_req = i[3];
            wr(`SMIG_ADDR_IRQ_CFG, {5'h00, i[2:0]});
            cyc(2);
            chk("irq_pin_o", {15'h0000, (i[2] | i[3]) ? i[0] : ~i[0]},
                {15'h0000, irq_pin_o});
            chk("irq_pin_oe", {15'h0000, i[2] | ~i[1] | i[3]},
                {15'h0000, irq_pin_oe});
        end
        $display("test interrupt pin done");

        // protected, single-write and open keys
        wr(`SMIG_ADDR_GUARD, `SMIG_KEY_LOCKED);
        wr(`SMIG_ADDR_IRQ_CFG, 8'h05);
        rd(`SMIG_ADDR_IRQ_CFG, 8'h07);
        wr(`SMIG_ADDR_GUARD, `SMIG_KEY_ONCE);
        wr(`SMIG_ADDR_IRQ_CFG, 8'h05);
        wr(`SMIG_ADDR_IRQ_CFG, 8'h01);
        rd(`SMIG_ADDR_IRQ_CFG, 8'h05);
        rd(`SMIG_ADDR_GUARD, `SMIG_KEY_LOCKED);
        wr(`SMIG_ADDR_GUARD, `SMIG_KEY_OPEN);
        wr(8'h70, 8'hFF);
        wr(`SMIG_ADDR_IRQ_CFG, 8'h02);
        rd(`SMIG_ADDR_IRQ_CFG, 8'h02);
        rd(8'h70, `SMIG_READ_NONE);
        $display("test write guard done");

        // two sync edges half a frame apart cannot both be in limit
        alarm_seen = 1'b0;
        for (i = 0; i < 272; i++)
        begin
            sync_pin = i[6] | i[8];
            cyc(1);
            alarm_seen = alarm_seen | (sync_alarm === 1'b1);
        end
        chk("sync_alarm seen", 16'h0001, {15'h0000, alarm_seen});
        lock_info.src = 4'h1;
        cyc(3);
        chk("sync_alarm", 16'h0000, {15'h0000, sync_alarm});
        chk("sync_aligned", 16'h0000, {15'h0000, sync_aligned});
        $display("test sync monitor done");
        cyc(3);
        give_verdict();
    end
endmodule // tb_top
